// File: rtl/dcf_pkg.sv
// Shared constants and types for the deep dual-clock FIFO
package dcf_pkg;
    localparam int DATA_W = 9;
    localparam int DEPTH_SMALL = 262144;
    localparam int DEPTH_LARGE = 524288;
    localparam int STAGE_DEPTH = 32;
    localparam int OFF_W = 18;
    localparam int SYNC_W = 20;
    localparam logic [17:0] OFFSET_PARALLEL_DEF = 18'h0007F;
    localparam logic [17:0] OFFSET_SERIAL_DEF = 18'h003FF;
    localparam logic [8:0] OUT_RESET = 9'h000;
    localparam logic [1:0] IDX_RESET = 2'h0;
    localparam logic [1:0] FT_LATENCY = 2'h3;
    localparam logic [2:0] REPLAY_HOLD = 3'h4;
    typedef enum logic [1:0] {RD_EMPTY, RD_FALL, RD_VALID} dcf_rd_state_type;
endpackage

// File: rtl/dcf_sync.sv
// Two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/10ps
`default_nettype none
module dcf_sync #(
    parameter int WIDTH = dcf_pkg::SYNC_W
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// File: rtl/dcf_stage_fifo.sv
// Small staging FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module dcf_stage_fifo #(
    parameter int WIDTH = dcf_pkg::DATA_W,
    parameter int DEPTH = dcf_pkg::STAGE_DEPTH
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic flush_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out,
    output logic [$clog2(DEPTH):0] count_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    assign count_out = wr_q - rd_q;
    assign in_ready_out = (count_out != (AW + 1)'(DEPTH));
    assign out_valid_out = (count_out != '0);
    assign out_data_out = store_q[rd_q[AW-1:0]];
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            store_q[wr_q[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_q <= '0;
            rd_q <= '0;
        end else if (flush_in) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: rtl/dcf_top.sv
// Deep FIFO with sampled write/read clocks, flags and offset registers
`timescale 1ns/10ps
`default_nettype none
module dcf_top #(
    parameter int MEM_DEPTH = dcf_pkg::DEPTH_SMALL,
    parameter int STAGE_DEPTH = dcf_pkg::STAGE_DEPTH
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic write_clock_in,
    input wire logic write_enable_n_in,
    input wire logic [8:0] write_data_bus_in,
    input wire logic read_clock_in,
    input wire logic read_enable_n_in,
    input wire logic output_enable_n_in,
    input wire logic serial_load_enable_n_in,
    input wire logic offset_access_select_n_in,
    input wire logic mode_or_serial_input_in,
    input wire logic full_reset_n_in,
    input wire logic partial_reset_n_in,
    input wire logic replay_trigger_n_in,
    output logic [8:0] read_data_bus_out,
    output logic read_data_oe_n_out,
    output logic full_or_input_ready_n_out,
    output logic empty_or_output_ready_n_out,
    output logic almost_full_n_out,
    output logic almost_empty_n_out,
    output logic half_full_n_out,
    output logic fall_through_mode_out,
    output logic serial_program_out
);
    localparam int ADDR_W = $clog2(MEM_DEPTH);
    localparam int PTR_W = ADDR_W + 1;
    localparam int SCNT_W = $clog2(STAGE_DEPTH) + 1;
    localparam logic [PTR_W-1:0] DEPTH_V = PTR_W'(MEM_DEPTH);
    localparam logic [PTR_W-1:0] HALF_V = PTR_W'(MEM_DEPTH / 2);
    localparam int CMP_W = ((PTR_W > dcf_pkg::OFF_W) ? PTR_W : dcf_pkg::OFF_W) + 1;

    //--------------------------------------------------------------
    // Pin synchronisation
    //--------------------------------------------------------------
    logic [dcf_pkg::SYNC_W-1:0] pins_s;
    logic wclk_s;
    logic rclk_s;
    logic wen_n_s;
    logic ren_n_s;
    logic oe_n_s;
    logic shift_n_s;
    logic osel_n_s;
    logic si_s;
    logic frst_n_s;
    logic prst_n_s;
    logic rply_n_s;
    logic [8:0] wdata_s;
    logic wclk_prev_q;
    logic rclk_prev_q;
    logic wr_edge;
    logic rd_edge;

    dcf_sync #(
        .WIDTH(dcf_pkg::SYNC_W)
    ) u_sync (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .async_in({write_clock_in, read_clock_in, write_enable_n_in,
                   read_enable_n_in, output_enable_n_in,
                   serial_load_enable_n_in, offset_access_select_n_in,
                   mode_or_serial_input_in, full_reset_n_in,
                   partial_reset_n_in, replay_trigger_n_in,
                   write_data_bus_in}),
        .sync_out(pins_s)
    );

    assign {wclk_s, rclk_s, wen_n_s, ren_n_s, oe_n_s, shift_n_s, osel_n_s,
            si_s, frst_n_s, prst_n_s, rply_n_s, wdata_s} = pins_s;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wclk_prev_q <= 1'b0;
            rclk_prev_q <= 1'b0;
        end else begin
            wclk_prev_q <= wclk_s;
            rclk_prev_q <= rclk_s;
        end
    end

    // Rising edges of the sampled producer and consumer clocks
    assign wr_edge = wclk_s & ~wclk_prev_q;
    assign rd_edge = rclk_s & ~rclk_prev_q;

    //--------------------------------------------------------------
    // Configuration latched during full reset
    //--------------------------------------------------------------
    logic fall_through_q;
    logic serial_mode_q;
    logic clear_data;

    assign clear_data = ~frst_n_s | ~prst_n_s;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fall_through_q <= 1'b0;
            serial_mode_q <= 1'b0;
        end else if (!frst_n_s) begin
            fall_through_q <= si_s;
            serial_mode_q <= osel_n_s;
        end
    end

    //--------------------------------------------------------------
    // Offset registers
    //--------------------------------------------------------------
    logic [dcf_pkg::OFF_W-1:0] empty_off_q;
    logic [dcf_pkg::OFF_W-1:0] full_off_q;
    logic [1:0] wr_idx_q;
    logic [1:0] rd_idx_q;
    logic ser_load;
    logic par_load;
    logic off_rd_req;

    assign ser_load = frst_n_s & wr_edge & ~osel_n_s & ~shift_n_s & serial_mode_q;
    assign par_load = frst_n_s & wr_edge & ~osel_n_s & ~wen_n_s & ~serial_mode_q & shift_n_s;
    assign off_rd_req = frst_n_s & rd_edge & ~ren_n_s & ~osel_n_s;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            empty_off_q <= dcf_pkg::OFFSET_PARALLEL_DEF;
            full_off_q <= dcf_pkg::OFFSET_PARALLEL_DEF;
        end else if (!frst_n_s) begin
            if (osel_n_s) begin
                empty_off_q <= dcf_pkg::OFFSET_SERIAL_DEF;
                full_off_q <= dcf_pkg::OFFSET_SERIAL_DEF;
            end else begin
                empty_off_q <= dcf_pkg::OFFSET_PARALLEL_DEF;
                full_off_q <= dcf_pkg::OFFSET_PARALLEL_DEF;
            end
        end else if (ser_load) begin
            // Bits enter empty offset LSB and ripple up into full offset
            {full_off_q, empty_off_q} <= {full_off_q[dcf_pkg::OFF_W-2:0], empty_off_q, si_s};
        end else if (par_load) begin
            case (wr_idx_q)
                2'h0: empty_off_q[8:0] <= wdata_s;
                2'h1: empty_off_q[17:9] <= wdata_s;
                2'h2: full_off_q[8:0] <= wdata_s;
                default: full_off_q[17:9] <= wdata_s;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_idx_q <= dcf_pkg::IDX_RESET;
        end else if (!frst_n_s) begin
            wr_idx_q <= dcf_pkg::IDX_RESET;
        end else if (par_load) begin
            wr_idx_q <= wr_idx_q + 2'h1;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_idx_q <= dcf_pkg::IDX_RESET;
        end else if (!frst_n_s) begin
            rd_idx_q <= dcf_pkg::IDX_RESET;
        end else if (off_rd_req) begin
            rd_idx_q <= rd_idx_q + 2'h1;
        end
    end

    function automatic logic [8:0] off_word(input logic [1:0] idx,
                                            input logic [17:0] e_off,
                                            input logic [17:0] f_off);
        case (idx)
            2'h0: off_word = e_off[8:0];
            2'h1: off_word = e_off[17:9];
            2'h2: off_word = f_off[8:0];
            default: off_word = f_off[17:9];
        endcase
    endfunction

    //--------------------------------------------------------------
    // Write path through the staging FIFO into memory
    //--------------------------------------------------------------
    logic [8:0] mem [MEM_DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [PTR_W-1:0] mem_count;
    logic [PTR_W-1:0] total;
    logic [SCNT_W-1:0] stage_count;
    logic stage_in_valid;
    logic stage_in_ready;
    logic stage_out_valid;
    logic stage_out_ready;
    logic [8:0] stage_out_data;
    logic wr_req;
    logic drain;
    logic full_now;

    assign mem_count = wr_ptr_q - rd_ptr_q;
    assign total = mem_count + PTR_W'(stage_count);
    assign full_now = (total >= DEPTH_V) | ~stage_in_ready;
    assign wr_req = wr_edge & ~wen_n_s & osel_n_s & ~clear_data;
    assign stage_in_valid = wr_req & (total < DEPTH_V);
    assign stage_out_ready = ~clear_data & (mem_count < DEPTH_V);
    assign drain = stage_out_valid & stage_out_ready;

    dcf_stage_fifo #(
        .WIDTH(dcf_pkg::DATA_W),
        .DEPTH(STAGE_DEPTH)
    ) u_stage (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .flush_in(clear_data),
        .in_valid_in(stage_in_valid),
        .in_ready_out(stage_in_ready),
        .in_data_in(wdata_s),
        .out_valid_out(stage_out_valid),
        .out_ready_in(stage_out_ready),
        .out_data_out(stage_out_data),
        .count_out(stage_count)
    );

    always_ff @(posedge clk_in) begin
        if (drain) begin
            mem[wr_ptr_q[ADDR_W-1:0]] <= stage_out_data;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_ptr_q <= '0;
        end else if (clear_data) begin
            wr_ptr_q <= '0;
        end else if (drain) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
        end
    end

    //--------------------------------------------------------------
    // Read path and replay
    //--------------------------------------------------------------
    dcf_pkg::dcf_rd_state_type rd_state_q;
    logic [1:0] ft_cnt_q;
    logic [2:0] replay_hold_q;
    logic [8:0] out_q;
    logic replay_req;
    logic replaying;
    logic rd_data_req;
    logic mem_has;
    logic ft_fire;
    logic pop;

    assign replay_req = rd_edge & ~rply_n_s & ~clear_data;
    assign replaying = (replay_hold_q != 3'h0);
    assign mem_has = (mem_count != '0);
    assign rd_data_req = rd_edge & ~ren_n_s & osel_n_s;
    assign ft_fire = (rd_state_q == dcf_pkg::RD_FALL) & rd_edge & (ft_cnt_q == dcf_pkg::FT_LATENCY - 2'h1);

    always_comb begin
        pop = 1'b0;
        if (!clear_data && !replay_req && !replaying && mem_has) begin
            if (fall_through_q) begin
                pop = ft_fire | ((rd_state_q == dcf_pkg::RD_VALID) & rd_data_req);
            end else begin
                pop = rd_data_req;
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_ptr_q <= '0;
        end else if (clear_data || replay_req) begin
            rd_ptr_q <= '0;
        end else if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            replay_hold_q <= 3'h0;
        end else if (clear_data) begin
            replay_hold_q <= 3'h0;
        end else if (replay_req) begin
            replay_hold_q <= dcf_pkg::REPLAY_HOLD;
        end else if (replaying) begin
            replay_hold_q <= replay_hold_q - 3'h1;
        end
    end

    // Fall-through sequencing: wait three read edges, then present a word
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_state_q <= dcf_pkg::RD_EMPTY;
            ft_cnt_q <= 2'h0;
        end else if (clear_data || replay_req || !fall_through_q) begin
            rd_state_q <= dcf_pkg::RD_EMPTY;
            ft_cnt_q <= 2'h0;
        end else begin
            case (rd_state_q)
                dcf_pkg::RD_EMPTY: begin
                    ft_cnt_q <= 2'h0;
                    if (mem_has && !replaying) begin
                        rd_state_q <= dcf_pkg::RD_FALL;
                    end
                end
                dcf_pkg::RD_FALL: begin
                    if (ft_fire) begin
                        rd_state_q <= dcf_pkg::RD_VALID;
                    end else if (rd_edge) begin
                        ft_cnt_q <= ft_cnt_q + 2'h1;
                    end
                end
                dcf_pkg::RD_VALID: begin
                    if (rd_data_req && !mem_has) begin
                        rd_state_q <= dcf_pkg::RD_EMPTY;
                    end
                end
                default: begin
                    rd_state_q <= dcf_pkg::RD_EMPTY;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            out_q <= dcf_pkg::OUT_RESET;
        end else if (clear_data) begin
            out_q <= dcf_pkg::OUT_RESET;
        end else if (pop) begin
            out_q <= mem[rd_ptr_q[ADDR_W-1:0]];
        end else if (off_rd_req) begin
            out_q <= off_word(rd_idx_q, empty_off_q, full_off_q);
        end
    end

    //--------------------------------------------------------------
    // Flags and output drive
    //--------------------------------------------------------------
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            full_or_input_ready_n_out <= 1'b1;
            empty_or_output_ready_n_out <= 1'b1;
            almost_full_n_out <= 1'b1;
            almost_empty_n_out <= 1'b1;
            half_full_n_out <= 1'b1;
        end else begin
            if (fall_through_q) begin
                full_or_input_ready_n_out <= full_now;
                empty_or_output_ready_n_out <= (rd_state_q != dcf_pkg::RD_VALID) | replaying;
            end else begin
                full_or_input_ready_n_out <= ~full_now;
                empty_or_output_ready_n_out <= mem_has & ~replaying;
            end
            // Wide compare so offsets larger than the memory do not wrap
            almost_full_n_out <= ~((CMP_W'(total) + CMP_W'(full_off_q)) > CMP_W'(MEM_DEPTH));
            almost_empty_n_out <= ~(CMP_W'(total) < CMP_W'(empty_off_q));
            half_full_n_out <= ~(total > HALF_V);
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            read_data_bus_out <= dcf_pkg::OUT_RESET;
            read_data_oe_n_out <= 1'b1;
            fall_through_mode_out <= 1'b0;
            serial_program_out <= 1'b0;
        end else begin
            read_data_bus_out <= out_q;
            read_data_oe_n_out <= oe_n_s;
            fall_through_mode_out <= fall_through_q;
            serial_program_out <= serial_mode_q;
        end
    end
endmodule
`default_nettype wire

// File: sim/dcf_top_monitor.sv
// Concurrent checks on the deep FIFO top ports
`timescale 1ns/10ps
`default_nettype none
module dcf_top_monitor (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic read_clock_in,
    input wire logic output_enable_n_in,
    input wire logic offset_access_select_n_in,
    input wire logic mode_or_serial_input_in,
    input wire logic full_reset_n_in,
    input wire logic partial_reset_n_in,
    input wire logic [8:0] read_data_bus_out,
    input wire logic read_data_oe_n_out,
    input wire logic full_or_input_ready_n_out,
    input wire logic empty_or_output_ready_n_out,
    input wire logic half_full_n_out,
    input wire logic almost_full_n_out,
    input wire logic fall_through_mode_out,
    input wire logic serial_program_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    property p_oe_off;
        output_enable_n_in [*4] |-> read_data_oe_n_out;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("bus driven while disabled");
    property p_oe_on;
        (!output_enable_n_in) [*4] |-> !read_data_oe_n_out;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("bus released while enabled");
    property p_full_clear;
        (!full_reset_n_in) [*4] |-> ##2 read_data_bus_out == 9'h000;
    endproperty
    a_full_clear: assert property (p_full_clear) else $error("output not cleared by full reset");
    property p_part_clear;
        (!partial_reset_n_in) [*4] |-> ##2 read_data_bus_out == 9'h000;
    endproperty
    a_part_clear: assert property (p_part_clear) else $error("output not cleared by partial reset");
    property p_mode_latch;
        (!full_reset_n_in && mode_or_serial_input_in) [*4] |-> ##2 fall_through_mode_out;
    endproperty
    a_mode_latch: assert property (p_mode_latch) else $error("mode not latched");
    property p_method_latch;
        (!full_reset_n_in && !offset_access_select_n_in) [*4] |-> ##2 !serial_program_out;
    endproperty
    a_method_latch: assert property (p_method_latch) else $error("method not latched");
    property p_cfg_hold;
        full_reset_n_in [*4] |-> $stable(fall_through_mode_out) && $stable(serial_program_out);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config moved outside full reset");
    property p_full_flags;
        !fall_through_mode_out && !full_or_input_ready_n_out |-> !half_full_n_out && !almost_full_n_out;
    endproperty
    a_full_flags: assert property (p_full_flags) else $error("full without level flags");
    property p_empty_flags;
        !fall_through_mode_out && !empty_or_output_ready_n_out |-> half_full_n_out;
    endproperty
    a_empty_flags: assert property (p_empty_flags) else $error("empty with half flag");
    property p_data_hold;
        (!read_clock_in && full_reset_n_in && partial_reset_n_in) [*6] |-> $stable(read_data_bus_out);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("output moved without read edge");
endmodule
bind dcf_top dcf_top_monitor u_mon (.clk_in, .nrst_in, .read_clock_in, .output_enable_n_in,
    .offset_access_select_n_in, .mode_or_serial_input_in, .full_reset_n_in, .partial_reset_n_in,
    .read_data_bus_out, .read_data_oe_n_out, .full_or_input_ready_n_out, .empty_or_output_ready_n_out,
    .half_full_n_out, .almost_full_n_out, .fall_through_mode_out, .serial_program_out);
`default_nettype wire

// File: sim/dcf_port_model.sv
// Producer and consumer model pacing the sampled pin clocks
`timescale 1ns/10ps
`default_nettype none
module dcf_port_model (
    input wire logic clk_in,
    output logic wclk_out,
    output logic wen_n_out,
    output logic [8:0] wdata_out,
    output logic shift_n_out,
    output logic si_out,
    output logic rclk_out,
    output logic ren_n_out,
    output logic replay_n_out
);
    initial begin
        {wclk_out, rclk_out, si_out} = 3'h0;
        {wen_n_out, shift_n_out, ren_n_out, replay_n_out} = 4'hF;
        wdata_out = 9'h155;
    end
    // The unused tied pin is not modelled; it stays at one fixed level
    task automatic gap(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic set_si(input logic b);
        si_out = b;
    endtask
    // Enables and data held three cycles before and four cycles after the rising edge
    task automatic wr(input logic [8:0] d, input logic shift_n, input logic si);
        @(negedge clk_in);
        wdata_out = d;
        wen_n_out = ~shift_n;
        shift_n_out = shift_n;
        si_out = si;
        gap(3);
        wclk_out = 1'b1;
        gap(3);
        wclk_out = 1'b0;
        gap(1);
        {wen_n_out, shift_n_out} = 2'h3;
        wdata_out = ~d;
        si_out = ~si;
        gap(2);
    endtask
    task automatic rd(input logic ren_n, input logic replay_n);
        @(negedge clk_in);
        ren_n_out = ren_n;
        replay_n_out = replay_n;
        gap(3);
        rclk_out = 1'b1;
        gap(3);
        rclk_out = 1'b0;
        gap(1);
        {ren_n_out, replay_n_out} = 2'h3;
        gap(2);
    endtask
endmodule
`default_nettype wire

// File: sim/test_dcf_top.sv
// Self-checking bench for the deep dual-clock FIFO
`timescale 1ns/10ps
`default_nettype none
module test_dcf_top;
    logic clk_in;
    logic nrst_in;
    logic oe_n, sel_n, frst_n, prst_n;
    logic wclk, wen_n, shift_n, si, rclk, ren_n, replay_n;
    logic [8:0] wdata, q;
    logic q_oe_n, full_n, empty_n, afull_n, aempty_n, half_n, ft, sp;
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [8:0] dflt [4] = '{9'h07F, 9'h000, 9'h07F, 9'h000};
    logic [8:0] prog [4] = '{9'h002, 9'h000, 9'h003, 9'h000};
    logic [8:0] ser [4] = '{9'h005, 9'h000, 9'h006, 9'h000};
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    dcf_port_model pm (.clk_in(clk_in), .wclk_out(wclk), .wen_n_out(wen_n), .wdata_out(wdata),
        .shift_n_out(shift_n), .si_out(si), .rclk_out(rclk), .ren_n_out(ren_n), .replay_n_out(replay_n));
    dcf_top #(.MEM_DEPTH(64), .STAGE_DEPTH(32)) dut (.clk_in(clk_in), .nrst_in(nrst_in),
        .write_clock_in(wclk), .write_enable_n_in(wen_n), .write_data_bus_in(wdata),
        .read_clock_in(rclk), .read_enable_n_in(ren_n), .output_enable_n_in(oe_n),
        .serial_load_enable_n_in(shift_n), .offset_access_select_n_in(sel_n), .mode_or_serial_input_in(si),
        .full_reset_n_in(frst_n), .partial_reset_n_in(prst_n), .replay_trigger_n_in(replay_n),
        .read_data_bus_out(q), .read_data_oe_n_out(q_oe_n), .full_or_input_ready_n_out(full_n),
        .empty_or_output_ready_n_out(empty_n), .almost_full_n_out(afull_n), .almost_empty_n_out(aempty_n),
        .half_full_n_out(half_n), .fall_through_mode_out(ft), .serial_program_out(sp));
    task automatic chk_word(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("Comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            test_done();
        end
    end
    task automatic mres(input logic mode, input logic sel);
        @(negedge clk_in);
        pm.set_si(mode);
        sel_n = sel;
        frst_n = 1'b0;
        repeat (6) @(negedge clk_in);
        frst_n = 1'b1;
        repeat (4) @(negedge clk_in);
        sel_n = 1'b1;
        repeat (4) @(negedge clk_in);
    endtask
    task automatic t_standard;
        mres(1'b0, 1'b0);
        chk_word(q, 9'h000);
        chk_bit(ft, 1'b0);
        chk_bit(sp, 1'b0);
        chk_bit(empty_n, 1'b0);
        chk_bit(full_n, 1'b1);
        chk_bit(aempty_n, 1'b0);
        chk_bit(half_n, 1'b1);
        oe_n = 1'b0;
        repeat (4) @(negedge clk_in);
        chk_bit(q_oe_n, 1'b0);
        oe_n = 1'b1;
        repeat (4) @(negedge clk_in);
        chk_bit(q_oe_n, 1'b1);
        sel_n = 1'b0;
        for (int i = 0; i < 4; i++) begin
            pm.rd(1'b0, 1'b1);
            chk_word(q, dflt[i]);
        end
        for (int i = 0; i < 4; i++) pm.wr(prog[i], 1'b1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            pm.rd(1'b0, 1'b1);
            chk_word(q, prog[i]);
        end
        sel_n = 1'b1;
    endtask
    task automatic t_fill;
        int n;
        int j;
        pm.wr(9'h000, 1'b1, 1'b0);
        chk_bit(aempty_n, 1'b0);
        pm.wr(9'h001, 1'b1, 1'b0);
        chk_bit(aempty_n, 1'b1);
        n = 2;
        while (full_n === 1'b1 && n < 120) begin
            pm.wr(n[8:0], 1'b1, 1'b0);
            n++;
        end
        chk_bit(1'(n == 64), 1'b1);
        chk_bit(afull_n, 1'b0);
        chk_bit(half_n, 1'b0);
        pm.wr(9'h1FF, 1'b1, 1'b0);
        j = 0;
        while (empty_n === 1'b1 && j < 120) begin
            pm.rd(1'b0, 1'b1);
            chk_word(q, j[8:0]);
            j++;
        end
        chk_bit(1'(j == n), 1'b1);
        pm.rd(1'b0, 1'b1);
        chk_word(q, 9'(n - 1));
    endtask
    task automatic t_replay;
        pm.wr(9'h0A1, 1'b1, 1'b0);
        pm.wr(9'h0A2, 1'b1, 1'b0);
        pm.rd(1'b0, 1'b1);
        chk_word(q, 9'h0A1);
        prst_n = 1'b0;
        repeat (6) @(negedge clk_in);
        prst_n = 1'b1;
        repeat (4) @(negedge clk_in);
        chk_word(q, 9'h000);
        chk_bit(empty_n, 1'b0);
        chk_bit(ft, 1'b0);
        sel_n = 1'b0;
        pm.rd(1'b0, 1'b1);
        chk_word(q, 9'h002);
        sel_n = 1'b1;
        pm.wr(9'h0B1, 1'b1, 1'b0);
        pm.wr(9'h0B2, 1'b1, 1'b0);
        pm.rd(1'b0, 1'b1);
        pm.rd(1'b0, 1'b1);
        chk_word(q, 9'h0B2);
        chk_bit(empty_n, 1'b0);
        pm.rd(1'b1, 1'b0);
        chk_bit(empty_n, 1'b0);
        repeat (2) @(negedge clk_in);
        chk_bit(empty_n, 1'b1);
        pm.rd(1'b0, 1'b1);
        chk_word(q, 9'h0B1);
        pm.rd(1'b0, 1'b1);
        chk_word(q, 9'h0B2);
    endtask
    task automatic t_fall_through;
        logic [35:0] bits;
        mres(1'b1, 1'b1);
        chk_bit(ft, 1'b1);
        chk_bit(sp, 1'b1);
        chk_bit(empty_n, 1'b1);
        chk_bit(full_n, 1'b0);
        sel_n = 1'b0;
        for (int i = 0; i < 4; i++) begin
            pm.rd(1'b0, 1'b1);
            chk_word(q, i[0] ? 9'h001 : 9'h1FF);
        end
        bits = {18'h00006, 18'h00005};
        for (int k = 35; k >= 0; k--) pm.wr(9'h000, 1'b0, bits[k]);
        for (int i = 0; i < 4; i++) begin
            pm.rd(1'b0, 1'b1);
            chk_word(q, ser[i]);
        end
        sel_n = 1'b1;
        pm.wr(9'h0C3, 1'b1, 1'b0);
        pm.rd(1'b1, 1'b1);
        pm.rd(1'b1, 1'b1);
        chk_word(q, 9'h000);
        pm.rd(1'b1, 1'b1);
        chk_word(q, 9'h0C3);
        chk_bit(empty_n, 1'b0);
    endtask
    initial begin
        nrst_in = 1'b0;
        oe_n = 1'b1;
        sel_n = 1'b1;
        frst_n = 1'b0;
        prst_n = 1'b1;
        repeat (10) @(posedge clk_in);
        @(negedge clk_in);
        nrst_in = 1'b1;
        t_standard();
        t_fill();
        t_replay();
        t_fall_through();
        test_done();
    end
endmodule
`default_nettype wire
